// ---- wdc_adc_model.sv ----
/*
  Converter model: LANES samples per core clock on buses A and B,
  random or all-zero words while running.
  Assumes the testbench drives run and zero off the clock edge.
*/
`timescale 1ns/1ps
module wdc_adc_model #(
  parameter int LANES = 2
) (
  input  wire logic           core_clk_in,
  input  wire logic           rst_n_in,
  input  wire logic           run_in,
  input  wire logic           zero_in,
  output logic [12*LANES-1:0] adc_a_out,
  output logic [12*LANES-1:0] adc_b_out,
  output logic                adc_valid_out
);
  localparam int W = 12 * LANES;
  int seed;

  initial seed = 32'h2f05;

  // both sample-clock edges folded into LANES words per core clock
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      adc_valid_out <= 1'b0;
      adc_a_out     <= '0;
      adc_b_out     <= '0;
    end else if (run_in) begin
      adc_valid_out <= 1'b1;
      adc_a_out     <= zero_in ? '0 : W'($random(seed));
      adc_b_out     <= zero_in ? '0 : W'($random(seed));
    end else begin
      // idle bus toggles so a stale word never passes for a sample
      adc_valid_out <= 1'b0;
      adc_a_out     <= ~adc_a_out;
      adc_b_out     <= ~adc_b_out;
    end
  end
endmodule // wdc_adc_model

// ---- wdc_chan.sv ----
/*
  One downconverter channel: NCO mixer over a block of parallel samples,
  decimating FIR on the mixed stream, 16-bit I/Q output.
  Assumes LANES samples per core clock and coefficients written by the
  register file.
*/
`timescale 1ns/1ps
module wdc_chan
  import wdc_pkg::*;
#(
  parameter int LANES = 2,
  parameter int TAPS  = 8
) (
  input  wire logic                core_clk_in,
  input  wire logic                rst_n_in,
  input  wire logic [12*LANES-1:0] samp_in,
  input  wire logic                samp_valid_in,
  input  wire logic [31:0]         tune_in,
  input  wire logic [5:0]          dec_in,
  input  wire logic                coef_we_in,
  input  wire logic [2:0]          coef_addr_in,
  input  wire logic [15:0]         coef_data_in,
  input  wire logic                flush_in,
  output logic [31:0]              iq_out,
  output logic                     iq_valid_out
);
  logic [31:0]        phase_reg, phase_next;
  logic signed [15:0] coef_reg [TAPS];
  logic signed [15:0] coef_next [TAPS];
  logic signed [15:0] di_reg [TAPS], di_next [TAPS];
  logic signed [15:0] dq_reg [TAPS], dq_next [TAPS];
  logic [5:0]         cnt_reg, cnt_next;
  logic [31:0]        iq_reg, iq_next;
  logic               vld_reg, vld_next;
  logic signed [39:0] acc_i, acc_q;
  logic signed [15:0] mi, mq;

  // coarse quarter-wave LO: the top two phase bits pick sign and rail
  function automatic logic signed [15:0] mix(input logic signed [11:0] s,
                                             input logic [1:0] ph,
                                             input logic q);
    logic [1:0] p;
    p = q ? 2'(ph + 2'h3) : ph;
    case (p)
      2'h0:    mix = 16'(s) <<< 4;
      2'h2:    mix = -(16'(s) <<< 4);
      default: mix = 16'h0000;
    endcase
  endfunction

  always_comb begin
    phase_next = phase_reg;
    cnt_next   = cnt_reg;
    iq_next    = iq_reg;
    vld_next   = 1'b0;
    di_next    = di_reg;
    dq_next    = dq_reg;
    coef_next  = coef_reg;
    acc_i      = '0;
    acc_q      = '0;
    mi         = '0;
    mq         = '0;
    if (coef_we_in) begin
      coef_next[coef_addr_in] = coef_data_in;
    end
    if (flush_in) begin
      // discard history so stale data never reaches the output
      for (int k = 0; k < TAPS; k++) begin
        di_next[k] = '0;
        dq_next[k] = '0;
      end
      cnt_next   = '0;
      phase_next = '0;
    end else if (samp_valid_in) begin
      // every lane is consumed each clock, none dropped
      for (int l = 0; l < LANES; l++) begin
        mi = mix(samp_in[12*l +: 12], phase_next[31:30], 1'b0);
        mq = mix(samp_in[12*l +: 12], phase_next[31:30], 1'b1);
        phase_next = phase_next + tune_in;
        for (int k = TAPS-1; k > 0; k--) begin
          di_next[k] = di_next[k-1];
          dq_next[k] = dq_next[k-1];
        end
        di_next[0] = mi;
        dq_next[0] = mq;
      end
      for (int k = 0; k < TAPS; k++) begin
        acc_i = acc_i + 40'(di_next[k]) * 40'(coef_reg[k]);
        acc_q = acc_q + 40'(dq_next[k]) * 40'(coef_reg[k]);
      end
      // one output per dec_in input samples
      if (6'(cnt_reg + 6'(LANES)) >= dec_in) begin
        cnt_next = '0;
        iq_next  = {acc_i[31:16], acc_q[31:16]};
        vld_next = 1'b1;
      end else begin
        cnt_next = 6'(cnt_reg + 6'(LANES));
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_reg <= '0;
      cnt_reg   <= '0;
      iq_reg    <= '0;
      vld_reg   <= 1'b0;
      for (int k = 0; k < TAPS; k++) begin
        coef_reg[k] <= WDC_DEF_COEF[k];
        di_reg[k]   <= '0;
        dq_reg[k]   <= '0;
      end
    end else begin
      phase_reg <= phase_next;
      cnt_reg   <= cnt_next;
      iq_reg    <= iq_next;
      vld_reg   <= vld_next;
      coef_reg  <= coef_next;
      di_reg    <= di_next;
      dq_reg    <= dq_next;
    end
  end

  assign iq_out       = iq_reg;
  assign iq_valid_out = vld_reg;

endmodule // wdc_chan

// ---- wdc_chk.sv ----
/*
  Port checker for wdc_top: APB answer timing, error map, output hold
  and quiet periods after settings writes.
  Assumes it is bound onto wdc_top from the testbench top file.
*/
`timescale 1ns/1ps
module wdc_chk
  import wdc_pkg::*;
(
  input wire logic        core_clk_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [31:0] iq0_out,
  input wire logic        iq0_valid_out,
  input wire logic        iq0_ready_in,
  input wire logic [31:0] iq1_out,
  input wire logic        iq1_valid_out,
  input wire logic        iq1_ready_in
);
  logic       wr_done;
  logic [3:0] since_reg;
  logic [3:0] since_next;
  logic       two_reg;
  logic       two_next;
  logic       en_reg;
  logic       en_next;

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  // status and tap index writes do not flush
  assign wr_done = psel_in && penable_in && pready_out && pwrite_in &&
                   paddr_in <= WDC_COEF1_OFF && paddr_in != WDC_STAT_OFF;

  always_comb begin
    since_next = (since_reg == 4'hf) ? since_reg : since_reg + 4'h1;
    two_next   = two_reg;
    en_next    = en_reg;
    if (wr_done) begin
      since_next = 4'h0;
      if (paddr_in == WDC_CTRL_OFF) begin
        two_next = pwdata_in[WDC_CTRL_MODE_BIT];
        en_next  = pwdata_in[WDC_CTRL_EN_BIT];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      since_reg <= 4'hf;
      two_reg   <= 1'b0;
      en_reg    <= 1'b0;
    end else begin
      since_reg <= since_next;
      two_reg   <= two_next;
      en_reg    <= en_next;
    end
  end

  apb_wait_a: assert property (
    psel_in && $rose(penable_in) |-> !pready_out ##1 pready_out)
    else $error("apb answer not after one wait state");
  apb_pulse_a: assert property (
    pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  err_map_a: assert property (
    pready_out |-> pslverr_out == (paddr_in > WDC_CADDR_OFF))
    else $error("slave error does not match address map");
  err_rdata_a: assert property (
    pready_out && pslverr_out && !pwrite_in |-> prdata_out == 32'h0)
    else $error("unmapped read returned data");
  iq0_hold_a: assert property (
    iq0_valid_out && !iq0_ready_in |=> iq0_valid_out && $stable(iq0_out))
    else $error("channel 0 word changed before taken");
  iq1_hold_a: assert property (
    iq1_valid_out && !iq1_ready_in |=> iq1_valid_out && $stable(iq1_out))
    else $error("channel 1 word changed before taken");
  flush_quiet_a: assert property (
    since_reg inside {[4'h1:4'h4]} |-> !iq0_valid_out && !iq1_valid_out)
    else $error("output valid during flush");
  one_ch_quiet_a: assert property (
    since_reg > 4'h4 && !two_reg |-> !iq1_valid_out)
    else $error("channel 1 active in one-channel mode");
  idle_quiet_a: assert property (
    since_reg > 4'h4 && !en_reg |-> !iq0_valid_out && !iq1_valid_out)
    else $error("output valid while disabled");

  cover property (wr_done);
  cover property (iq0_valid_out && !iq0_ready_in);
  cover property (iq1_valid_out && iq1_ready_in);
endmodule // wdc_chk

// ---- wdc_fifo.sv ----
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes a single clock; width and depth are parameters, depth a power
  of two.
*/
`timescale 1ns/1ps
module wdc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic [WIDTH-1:0]      rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  input  wire logic             flush_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg, wr_ptr_next;
  logic [AW:0]      rd_ptr_reg, rd_ptr_next;
  logic             do_wr, do_rd;

  always_comb begin
    wr_ready_out = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
    rd_valid_out = wr_ptr_reg != rd_ptr_reg;
    rd_data_out  = mem[rd_ptr_reg[AW-1:0]];
    do_wr        = wr_valid_in && wr_ready_out;
    do_rd        = rd_valid_out && rd_ready_in;
    wr_ptr_next  = flush_in ? '0 : wr_ptr_reg + (AW+1)'(do_wr);
    rd_ptr_next  = flush_in ? '0 : rd_ptr_reg + (AW+1)'(do_rd);
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // storage has no reset, so it needs no reset value
  always_ff @(posedge core_clk_in) begin
    if (do_wr) begin
      mem[wr_ptr_reg[AW-1:0]] <= wr_data_in;
    end
  end

endmodule // wdc_fifo

// ---- wdc_pkg.sv ----
/*
  Constants and types shared by the downconverter core: register map,
  field positions, reset values, decimation encodings and mode types.
  Assumes a 32-bit APB master and a 200 MHz core clock.
*/
package wdc_pkg;

  // register byte offsets
  localparam logic [11:0] WDC_CTRL_OFF   = 12'h000;
  localparam logic [11:0] WDC_STAT_OFF   = 12'h004;
  localparam logic [11:0] WDC_TUNE0_OFF  = 12'h008;
  localparam logic [11:0] WDC_TUNE1_OFF  = 12'h00c;
  localparam logic [11:0] WDC_COEF0_OFF  = 12'h010;
  localparam logic [11:0] WDC_COEF1_OFF  = 12'h014;
  localparam logic [11:0] WDC_CADDR_OFF  = 12'h018;

  // control fields
  localparam int WDC_CTRL_MODE_BIT = 0;
  localparam int WDC_CTRL_DEC_LSB  = 4;
  localparam int WDC_CTRL_EN_BIT   = 8;

  localparam logic [31:0] WDC_CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] WDC_TUNE_RST  = 32'h0000_0000;

  // decimation code: 0 -> lowest, 1 -> middle, 2 -> highest, 3 illegal
  localparam logic [1:0] WDC_DEC_LO  = 2'h0;
  localparam logic [1:0] WDC_DEC_MID = 2'h1;
  localparam logic [1:0] WDC_DEC_HI  = 2'h2;

  localparam int WDC_TAPS       = 8;
  localparam int WDC_FIFO_DEPTH = 16;
  localparam int WDC_LANES      = 2;

  // default low-pass taps, symmetric, sum 0x3c00, just under a quarter of unity gain
  localparam logic [15:0] WDC_DEF_COEF [WDC_TAPS] = '{
    16'h0100, 16'h0400, 16'h0a00, 16'h0f00,
    16'h0f00, 16'h0a00, 16'h0400, 16'h0100};

  typedef enum logic [0:0] {
    WDC_MODE_ONE,
    WDC_MODE_TWO
  } wdc_mode_t;

  typedef enum logic [1:0] {
    WDC_ST_IDLE,
    WDC_ST_FLUSH,
    WDC_ST_RUN
  } wdc_state_t;

  // decimation factor from mode and code; illegal code falls to lowest
  function automatic logic [5:0] wdc_dec_factor(input logic two_ch,
                                                input logic [1:0] code);
    logic [5:0] base;
    base = two_ch ? 6'h04 : 6'h08;
    case (code)
      WDC_DEC_MID: wdc_dec_factor = 6'(base << 1);
      WDC_DEC_HI:  wdc_dec_factor = 6'(base << 2);
      default:     wdc_dec_factor = base;
    endcase
  endfunction

endpackage

// ---- wdc_top.sv ----
/*
  Wideband digital downconverter core: APB register file, mode and
  decimation control, two channels, flush sequencing, output FIFOs.
  Assumes converter words already in the core clock domain, LANES per
  clock, bus A feeding channel 0 and bus B channel 1 in two-channel mode.
*/
// Summary of operation
// - one-channel mode interleaves the lower-half lanes of buses A and B, upper lanes dropped
// - two-channel mode processes both converter channels at once
// - each channel keeps its own 32-bit tuning word
// - one-channel decimation is 8, 16 or 32
// - two-channel decimation is shared, 4, 8 or 16
// - each channel loads its own 16-bit coefficient set
// - default taps give 80 percent band, high rejection
// - outputs are 16-bit I plus 16-bit Q at input rate over N
`timescale 1ns/1ps
module wdc_top
  import wdc_pkg::*;
#(
  parameter int LANES = WDC_LANES,
  parameter int DEPTH = WDC_FIFO_DEPTH
) (
  input  wire logic                core_clk_in,
  input  wire logic                rst_n_in,
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [11:0]         paddr_in,
  input  wire logic [31:0]         pwdata_in,
  output logic [31:0]              prdata_out,
  output logic                     pready_out,
  output logic                     pslverr_out,
  input  wire logic [12*LANES-1:0] adc_a_in,
  input  wire logic [12*LANES-1:0] adc_b_in,
  input  wire logic                adc_valid_in,
  output logic [31:0]              iq0_out,
  output logic                     iq0_valid_out,
  input  wire logic                iq0_ready_in,
  output logic [31:0]              iq1_out,
  output logic                     iq1_valid_out,
  input  wire logic                iq1_ready_in
);
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] tune0_reg, tune0_next;
  logic [31:0] tune1_reg, tune1_next;
  logic [2:0]  caddr_reg, caddr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  logic        cwe0, cwe1, setting_chg;
  wdc_state_t  st_reg, st_next;
  logic [5:0]  fl_cnt_reg, fl_cnt_next;
  logic        ovf_reg, ovf_next;

  logic        two_ch, run, flush, acc_phase, mapped;
  logic [5:0]  dec_n;
  logic [31:0] c0_iq, c1_iq;
  logic        c0_v, c1_v, f0_ready, f1_ready;
  logic [31:0] f0_d, f1_d;
  logic        f0_v, f1_v;
  logic [31:0] o0_reg, o0_next, o1_reg, o1_next;
  logic        ov0_reg, ov0_next, ov1_reg, ov1_next;
  logic        samp_v;
  logic [12*LANES-1:0] ch0_samp;

  always_comb begin
    two_ch = ctrl_reg[WDC_CTRL_MODE_BIT];
    // illegal code maps to the lowest legal factor of the mode
    dec_n  = wdc_dec_factor(two_ch,
                            ctrl_reg[WDC_CTRL_DEC_LSB +: 2]);
    run    = ctrl_reg[WDC_CTRL_EN_BIT] && (st_reg == WDC_ST_RUN);
    flush  = st_reg != WDC_ST_RUN;
  end

  // APB: access phase with one wait state, error on unmapped offset
  always_comb begin
    acc_phase    = psel_in && penable_in && !pready_reg;
    ctrl_next    = ctrl_reg;
    tune0_next   = tune0_reg;
    tune1_next   = tune1_reg;
    caddr_next   = caddr_reg;
    prdata_next  = prdata_reg;
    pready_next  = acc_phase;
    pslverr_next = 1'b0;
    cwe0         = 1'b0;
    cwe1         = 1'b0;
    setting_chg  = 1'b0;
    mapped       = 1'b1;
    case (paddr_in)
      WDC_CTRL_OFF, WDC_STAT_OFF, WDC_TUNE0_OFF, WDC_TUNE1_OFF,
      WDC_COEF0_OFF, WDC_COEF1_OFF, WDC_CADDR_OFF: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    if (acc_phase) begin
      pslverr_next = !mapped;
      if (pwrite_in) begin
        case (paddr_in)
          WDC_CTRL_OFF: begin
            ctrl_next   = pwdata_in & 32'h0000_0131;
            setting_chg = 1'b1;
          end
          WDC_TUNE0_OFF: begin
            tune0_next  = pwdata_in;
            setting_chg = 1'b1;
          end
          WDC_TUNE1_OFF: begin
            tune1_next  = pwdata_in;
            setting_chg = 1'b1;
          end
          WDC_COEF0_OFF: begin
            cwe0        = 1'b1;
            setting_chg = 1'b1;
            caddr_next  = 3'(caddr_reg + 3'h1);
          end
          WDC_COEF1_OFF: begin
            cwe1        = 1'b1;
            setting_chg = 1'b1;
            caddr_next  = 3'(caddr_reg + 3'h1);
          end
          WDC_CADDR_OFF: caddr_next = pwdata_in[2:0];
          default: ;
        endcase
      end else begin
        case (paddr_in)
          WDC_CTRL_OFF:  prdata_next = ctrl_reg;
          WDC_STAT_OFF:  prdata_next = {24'h0, dec_n, ovf_reg, run};
          WDC_TUNE0_OFF: prdata_next = tune0_reg;
          WDC_TUNE1_OFF: prdata_next = tune1_reg;
          WDC_CADDR_OFF: prdata_next = {29'h0, caddr_reg};
          default:       prdata_next = 32'h0000_0000;
        endcase
      end
    end
  end

  // flush sequencer: hold filters clear, then refill a full tap window
  always_comb begin
    st_next     = st_reg;
    fl_cnt_next = fl_cnt_reg;
    case (st_reg)
      WDC_ST_IDLE: begin
        if (ctrl_reg[WDC_CTRL_EN_BIT]) begin
          st_next = WDC_ST_FLUSH;
        end
      end
      WDC_ST_FLUSH: begin
        st_next = WDC_ST_RUN;
      end
      WDC_ST_RUN: begin
        if (!ctrl_reg[WDC_CTRL_EN_BIT]) begin
          st_next = WDC_ST_IDLE;
        end
      end
      default: st_next = WDC_ST_IDLE;
    endcase
    if (setting_chg) begin
      st_next = WDC_ST_IDLE;
    end
    // samples needed before the taps hold only fresh data
    if (st_reg != WDC_ST_RUN) begin
      fl_cnt_next = 6'(WDC_TAPS);
    end else if (samp_v && fl_cnt_reg != 6'h00) begin
      fl_cnt_next = (fl_cnt_reg > 6'(LANES)) ? 6'(fl_cnt_reg - 6'(LANES))
                                             : 6'h00;
    end
  end

  // one-channel: both converter buses interleave into channel 0
  always_comb begin
    samp_v = run && adc_valid_in;
    for (int l = 0; l < LANES; l++) begin
      ch0_samp[12*l +: 12] = (l % 2 == 0) ? adc_a_in[12*(l/2) +: 12]
                                          : adc_b_in[12*(l/2) +: 12];
    end
    if (two_ch) begin
      ch0_samp = adc_a_in;
    end
  end

  wdc_chan #(.LANES(LANES), .TAPS(WDC_TAPS)) u_chan0 (
    .core_clk_in  (core_clk_in),
    .rst_n_in     (rst_n_in),
    .samp_in      (ch0_samp),
    .samp_valid_in(samp_v),
    .tune_in      (tune0_reg),
    .dec_in       (dec_n),
    .coef_we_in   (cwe0),
    .coef_addr_in (caddr_reg),
    .coef_data_in (pwdata_in[15:0]),
    .flush_in     (flush),
    .iq_out       (c0_iq),
    .iq_valid_out (c0_v)
  );

  wdc_chan #(.LANES(LANES), .TAPS(WDC_TAPS)) u_chan1 (
    .core_clk_in  (core_clk_in),
    .rst_n_in     (rst_n_in),
    .samp_in      (adc_b_in),
    .samp_valid_in(samp_v && two_ch),
    .tune_in      (tune1_reg),
    .dec_in       (dec_n),
    .coef_we_in   (cwe1),
    .coef_addr_in (caddr_reg),
    .coef_data_in (pwdata_in[15:0]),
    .flush_in     (flush),
    .iq_out       (c1_iq),
    .iq_valid_out (c1_v)
  );

  // results before the window refills are dropped
  wdc_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo0 (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .wr_data_in  (c0_iq),
    .wr_valid_in (c0_v && fl_cnt_reg == 6'h00),
    .wr_ready_out(f0_ready),
    .rd_data_out (f0_d),
    .rd_valid_out(f0_v),
    .rd_ready_in (!ov0_reg || iq0_ready_in),
    .flush_in    (flush)
  );

  wdc_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo1 (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .wr_data_in  (c1_iq),
    .wr_valid_in (c1_v && fl_cnt_reg == 6'h00),
    .wr_ready_out(f1_ready),
    .rd_data_out (f1_d),
    .rd_valid_out(f1_v),
    .rd_ready_in (!ov1_reg || iq1_ready_in),
    .flush_in    (flush)
  );

  // output stages registered; a result into a full FIFO is an overrun, sticky until a settings write
  always_comb begin
    o0_next  = o0_reg;
    ov0_next = ov0_reg;
    o1_next  = o1_reg;
    ov1_next = ov1_reg;
    if (!ov0_reg || iq0_ready_in) begin
      o0_next  = f0_d;
      ov0_next = f0_v && !flush;
    end
    if (!ov1_reg || iq1_ready_in) begin
      o1_next  = f1_d;
      ov1_next = f1_v && !flush;
    end
    ovf_next = ovf_reg || (c0_v && !f0_ready) || (c1_v && !f1_ready);
    if (setting_chg) begin
      ovf_next = (c0_v && !f0_ready) || (c1_v && !f1_ready);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_reg    <= WDC_CTRL_RST;
      tune0_reg   <= WDC_TUNE_RST;
      tune1_reg   <= WDC_TUNE_RST;
      caddr_reg   <= '0;
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      st_reg      <= WDC_ST_IDLE;
      fl_cnt_reg  <= '0;
      ovf_reg     <= 1'b0;
      o0_reg      <= '0;
      ov0_reg     <= 1'b0;
      o1_reg      <= '0;
      ov1_reg     <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      tune0_reg   <= tune0_next;
      tune1_reg   <= tune1_next;
      caddr_reg   <= caddr_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      st_reg      <= st_next;
      fl_cnt_reg  <= fl_cnt_next;
      ovf_reg     <= ovf_next;
      o0_reg      <= o0_next;
      ov0_reg     <= ov0_next;
      o1_reg      <= o1_next;
      ov1_reg     <= ov1_next;
    end
  end

  assign prdata_out    = prdata_reg;
  assign pready_out    = pready_reg;
  assign pslverr_out   = pslverr_reg;
  assign iq0_out       = o0_reg;
  assign iq0_valid_out = ov0_reg;
  assign iq1_out       = o1_reg;
  assign iq1_valid_out = ov1_reg;

endmodule // wdc_top

// ---- wdc_top_tb.sv ----
/*
  Self-checking bench for wdc_top: APB register tests, decimation
  table, zero-input streams in both modes, FIFO overrun and drain.
  Assumes wdc_chk and wdc_adc_model are compiled alongside.
*/
`timescale 1ns/1ps
module wdc_top_tb
  import wdc_pkg::*;
;
  logic        core_clk, rst_n, psel, penable, pwrite, run, zero;
  logic        rdy0, rdy1, pready, pslverr, adc_v, iq0_v, iq1_v;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, iq0, iq1, t0;
  logic [23:0] adc_a, adc_b;
  logic [31:0] q0[$], q1[$];
  int          miscompares, n_tests, n0, n1, seed, m, c, f;

  wdc_top #(.LANES(2), .DEPTH(16)) i_wdc_top (
    .core_clk_in(core_clk), .rst_n_in(rst_n), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .adc_a_in(adc_a), .adc_b_in(adc_b),
    .adc_valid_in(adc_v), .iq0_out(iq0), .iq0_valid_out(iq0_v),
    .iq0_ready_in(rdy0), .iq1_out(iq1), .iq1_valid_out(iq1_v),
    .iq1_ready_in(rdy1));

  wdc_adc_model #(.LANES(2)) i_wdc_adc_model (
    .core_clk_in(core_clk), .rst_n_in(rst_n), .run_in(run),
    .zero_in(zero), .adc_a_out(adc_a), .adc_b_out(adc_b),
    .adc_valid_out(adc_v));

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask

  task chk_rng(input int g, input int lo, input int hi);
    n_tests++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("[ERR] %0t count %0d not in %0d..%0d", $time, g, lo, hi);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic [31:0] e, input logic ee);
    int t;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge core_clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) begin
      miscompares++;
      $display("[ERR] %0t no apb answer", $time);
    end
    if (!w) chk(prdata, e);
    chk({31'h0, pslverr}, {31'h0, ee});
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  // counts one window of 400 samples per channel after a flush
  task window(input int nd, input logic two);
    n0 = 0;
    n1 = 0;
    // random stalls in one-channel mode keep the hold path busy
    repeat (200) begin
      if (!two) rdy0 <= 1'($random(seed));
      @(posedge core_clk);
    end
    run  <= 1'b0;
    rdy0 <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk_rng(n0, 400 / nd - 4, 400 / nd + 1);
    chk_rng(n1, two ? 400 / nd - 4 : 0, two ? 400 / nd + 1 : 0);
    q0.delete();
    q1.delete();
  endtask

  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // zero samples in must give zero words out
  always @(posedge core_clk) begin
    if (rst_n && iq0_v === 1'b1 && rdy0) begin
      n0++;
      if (q0.size() > 0) chk(iq0, q0.pop_front());
    end
    if (rst_n && iq1_v === 1'b1 && rdy1) begin
      n1++;
      if (q1.size() > 0) chk(iq1, q1.pop_front());
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    stop_test;
  end

  initial begin
    {rst_n, psel, penable, pwrite, run, zero} = 6'h0;
    {rdy0, rdy1} = 2'h3;
    paddr = 12'h000;
    pwdata = 32'h0;
    seed = 32'h2f05;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, WDC_CTRL_OFF, 32'h0, WDC_CTRL_RST, 1'b0);
    apb(1'b0, WDC_STAT_OFF, 32'h0, 32'h0000_0020, 1'b0);
    apb(1'b0, 12'h01c, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 12'h020, 32'hffff_ffff, 32'h0, 1'b1);
    t0 = $random(seed);
    apb(1'b1, WDC_TUNE0_OFF, t0, 32'h0, 1'b0);
    apb(1'b1, WDC_TUNE1_OFF, ~t0, 32'h0, 1'b0);
    apb(1'b0, WDC_TUNE0_OFF, 32'h0, t0, 1'b0);
    apb(1'b0, WDC_TUNE1_OFF, 32'h0, ~t0, 1'b0);
    apb(1'b1, WDC_CADDR_OFF, 32'h7, 32'h0, 1'b0);
    apb(1'b1, WDC_COEF0_OFF, {16'h0, t0[15:0]}, 32'h0, 1'b0);
    apb(1'b0, WDC_CADDR_OFF, 32'h0, 32'h0, 1'b0);
    apb(1'b1, WDC_COEF1_OFF, 32'h0000_0200, 32'h0, 1'b0);
    apb(1'b0, WDC_CADDR_OFF, 32'h0, 32'h1, 1'b0);
    $display("test registers done");
    for (m = 0; m < 2; m++) begin
      for (c = 0; c < 4; c++) begin
        f = (m ? 4 : 8) << ((c == 1) ? 1 : (c == 2) ? 2 : 0);
        apb(1'b1, WDC_CTRL_OFF, (c << 4) | m, 32'h0, 1'b0);
        apb(1'b0, WDC_STAT_OFF, 32'h0, f << 2, 1'b0);
      end
    end
    $display("test decimation done");
    zero <= 1'b1;
    run  <= 1'b1;
    repeat (420 / 8) q0.push_back(32'h0);
    apb(1'b1, WDC_CTRL_OFF, 32'h0000_0100, 32'h0, 1'b0);
    window(8, 1'b0);
    apb(1'b0, WDC_STAT_OFF, 32'h0, 32'h0000_0021, 1'b0);
    $display("test one channel done");
    repeat (420 / 4) begin
      q0.push_back(32'h0);
      q1.push_back(32'h0);
    end
    run <= 1'b1;
    apb(1'b1, WDC_CTRL_OFF, 32'h0000_0101, 32'h0, 1'b0);
    window(4, 1'b1);
    apb(1'b0, WDC_STAT_OFF, 32'h0, 32'h0000_0011, 1'b0);
    $display("test two channel done");
    zero <= 1'b0;
    run  <= 1'b1;
    rdy0 <= 1'b0;
    rdy1 <= 1'b0;
    apb(1'b1, WDC_TUNE1_OFF, $random(seed), 32'h0, 1'b0);
    repeat (100) @(posedge core_clk);
    apb(1'b0, WDC_STAT_OFF, 32'h0, 32'h0000_0013, 1'b0);
    run <= 1'b0;
    repeat (5) @(posedge core_clk);
    n0 = 0;
    n1 = 0;
    rdy0 <= 1'b1;
    rdy1 <= 1'b1;
    repeat (40) @(posedge core_clk);
    chk_rng(n0, WDC_FIFO_DEPTH, WDC_FIFO_DEPTH + 1);
    chk_rng(n1, WDC_FIFO_DEPTH, WDC_FIFO_DEPTH + 1);
    apb(1'b0, WDC_STAT_OFF, 32'h0, 32'h0000_0013, 1'b0);
    apb(1'b1, WDC_CTRL_OFF, 32'h0000_0001, 32'h0, 1'b0);
    apb(1'b0, WDC_STAT_OFF, 32'h0, 32'h0000_0010, 1'b0);
    $display("test overrun done");
    stop_test;
  end
endmodule // wdc_top_tb

bind wdc_top wdc_chk i_wdc_chk (
  .core_clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .iq0_out,
  .iq0_valid_out, .iq0_ready_in, .iq1_out, .iq1_valid_out, .iq1_ready_in);
